/* rtl/dp_float_mul_div_seq.sv */
// Double-precision floating multiply and divide-entry sequencer with APB registers
// Behaviour
// RULE_01 - Multiplier bit 35 set: add, then shift right
// RULE_02 - Step counter each iteration, leave at zero
// RULE_03 - Preset counter to octal 33 per loop
// RULE_04 - Swap fractions, park first partial product
// RULE_05 - Keep high half, truncate low half
// RULE_06 - Add characteristics, remove octal 200 bias
// RULE_07 - Add partial products, remember bit 9 carry
// RULE_08 - Remembered carry injected at bit 35
// RULE_09 - Carry out of 9: shift right, set 9
// RULE_10 - Normalize one place, decrement characteristic
// RULE_11 - Low characteristic is high minus 27
// RULE_12 - Zero result clears both fractions
// RULE_13 - Divisor from even address, then next
// RULE_14 - Zero test, then 2:1 overflow divide check
// RULE_15 - Zero dividend: clear characteristics, plus sign
// RULE_16 - Take characteristic difference before equalization
// RULE_17 - Quotient spill: counter minus one, characteristic plus
// RULE_18 - Latch register is 27 bits wide
// RULE_19 - Major loop keeps accumulated partial products
// RULE_20 - Start with op select, one-cycle done
`timescale 1ns/10ps
`default_nettype none
module dp_float_mul_div_seq
    import dp_float_mul_div_seq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [7:0]        paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   memRead,
    output logic [ADDR_W-1:0]      memAddr,
    input  wire logic              memAck,
    input  wire logic [35:0]       memData,
    output logic                   done,
    output logic                   divideCheck
);
    // ==========================================================
    // Working registers
    seq_state_t        state;
    logic              opDivide;
    logic [ADDR_W-1:0] operandAddr;
    logic              acSign;
    logic [ACH_W-1:0]  acChar;
    logic [FRAC_W-1:0] acFrac;
    logic              mqSign;
    logic [CHAR_W-1:0] mqChar;
    logic [FRAC_W-1:0] mqFrac;
    logic              srSign;
    logic [CHAR_W-1:0] srChar;
    logic [FRAC_W-1:0] srFrac;
    logic [FRAC_W-1:0] swapFrac;
    logic [FRAC_W-1:0] latchFrac;          // RULE_18
    logic [FRAC_W-1:0] highMultiplier;
    logic [5:0]        iterationCounter;
    logic              carryRemembered;
    logic              zeroRemembered;
    logic [ACH_W-1:0]  charDiff;
    logic              busy;
    logic              startPulse;
    logic              writeAccess;
    logic              clearCheck;
    logic [FRAC_W:0]   addSum;
    logic [FRAC_W:0]   incSum;
    logic              fracZero;
    logic              divOverflow;
    logic              dividendGeDivisor;

    // ==========================================================
    // Shared adder and tests
    assign addSum   = {1'b0, acFrac} + {1'b0, srFrac};
    assign incSum   = {1'b0, acFrac} + {{FRAC_W{1'b0}}, 1'b1};
    assign fracZero = (acFrac == '0) && (mqFrac == '0);
    assign divOverflow       = {1'b0, acFrac, mqFrac} >= {srFrac, swapFrac, 1'b0};
    assign dividendGeDivisor = {acFrac, mqFrac} >= {srFrac, swapFrac};
    assign busy = (state != ST_IDLE);

    // ==========================================================
    // APB decode
    assign pready      = 1'b1;
    assign writeAccess = psel && penable && pwrite;
    assign startPulse  = writeAccess && (paddr == CTRL_OFS) && pwdata[CTRL_START_BIT] && !busy;
    assign clearCheck  = writeAccess && (paddr == STATUS_OFS) && pwdata[STAT_DCHK_BIT];

    // Unmapped offsets answer with an error
    always_comb begin
        case (paddr)
            CTRL_OFS, STATUS_OFS, ADDR_OFS, ACC_HEAD_OFS,
            ACC_FRAC_OFS, MQ_HEAD_OFS, MQ_FRAC_OFS, CHAR_DIFF_OFS: pslverr = 1'b0;
            default: pslverr = psel && penable;
        endcase
    end

    // Read data captured in the setup cycle
    always_ff @(posedge clk) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                CTRL_OFS:      prdata <= {30'h0, opDivide, 1'b0};
                STATUS_OFS:    prdata <= {29'h0, zeroRemembered, divideCheck, busy};
                ADDR_OFS:      prdata <= {17'h0, operandAddr};
                ACC_HEAD_OFS:  prdata <= {21'h0, acSign, acChar};
                ACC_FRAC_OFS:  prdata <= {5'h0, acFrac};
                MQ_HEAD_OFS:   prdata <= {23'h0, mqSign, mqChar};
                MQ_FRAC_OFS:   prdata <= {5'h0, mqFrac};
                CHAR_DIFF_OFS: prdata <= {22'h0, charDiff};
                default:       prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Operation select and operand address
    always_ff @(posedge clk) begin
        if (rst) begin
            opDivide    <= 1'b0;
            operandAddr <= '0;
        end else begin
            if (startPulse) begin
                opDivide <= pwdata[CTRL_DIVIDE_BIT];             // RULE_20
            end
            if (writeAccess && paddr == ADDR_OFS && !busy) begin
                operandAddr <= pwdata[ADDR_W-1:0];
            end
        end
    end

    // ==========================================================
    // Sequencer
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE:   if (startPulse) state <= ST_FETCH1;
                ST_FETCH1: if (memAck) state <= ST_FETCH2;
                ST_FETCH2: if (memAck) state <= opDivide ? ST_DZERO : ST_MZERO;
                ST_MZERO:  state <= fracZero ? ST_DONE : ST_ARR1;
                ST_ARR1:   state <= ST_LOOP1;
                ST_LOOP1:  if (iterationCounter == 6'd1) state <= ST_ARR2;   // RULE_02
                ST_ARR2:   state <= ST_LOOP2;
                ST_LOOP2:  if (iterationCounter == 6'd1) state <= ST_CHAR;
                ST_CHAR:   state <= ST_SUMPP;
                ST_SUMPP:  state <= ST_LOOP3;                          // RULE_19
                ST_LOOP3:  if (iterationCounter == 6'd1) state <= ST_CARRY;
                ST_CARRY:  state <= ST_NORM;
                ST_NORM:   state <= ST_LOWCH;
                ST_LOWCH:  state <= ST_DONE;
                ST_DZERO:  state <= ST_DOVF;
                ST_DOVF:   state <= (divOverflow || zeroRemembered) ? ST_DONE : ST_DADJ;
                ST_DADJ:   state <= ST_DONE;
                ST_DONE:   state <= ST_IDLE;
                default:   state <= ST_IDLE;
            endcase
        end
    end

    // Done pulse in the cycle after the last step
    assign done = (state == ST_DONE);                                  // RULE_20

    // Operand fetch, even word first then its neighbour
    assign memRead = (state == ST_FETCH1) || (state == ST_FETCH2);
    always_comb begin
        memAddr = {operandAddr[ADDR_W-1:1], 1'b0};                     // RULE_13
        if (state == ST_FETCH2) begin
            memAddr = {operandAddr[ADDR_W-1:1], 1'b1};
        end
    end

    // Divide check indicator, a new overflow wins over a clear
    always_ff @(posedge clk) begin
        if (rst) begin
            divideCheck <= 1'b0;
        end else if (state == ST_DOVF && divOverflow) begin
            divideCheck <= 1'b1;                                       // RULE_14
        end else if (clearCheck) begin
            divideCheck <= 1'b0;
        end
    end

    // Storage, swap, latch and saved multiplier fraction
    always_ff @(posedge clk) begin
        if (rst) begin
            srSign         <= 1'b0;
            srChar         <= '0;
            srFrac         <= '0;
            swapFrac       <= '0;
            latchFrac      <= '0;
            highMultiplier <= '0;
        end else begin
            case (state)
                ST_FETCH1: if (memAck) begin
                    srSign <= memData[WORD_SIGN_BIT];                  // RULE_13
                    srChar <= memData[34:27];
                    srFrac <= memData[FRAC_W-1:0];
                end
                ST_FETCH2: if (memAck) swapFrac <= memData[FRAC_W-1:0];
                ST_ARR1:   highMultiplier <= acFrac;
                ST_ARR2: begin
                    srFrac    <= swapFrac;                             // RULE_04
                    swapFrac  <= srFrac;
                    latchFrac <= acFrac;                               // RULE_04
                end
                ST_SUMPP:  srFrac <= swapFrac;
                default: ;
            endcase
        end
    end

    // Shift counter presets and steps
    always_ff @(posedge clk) begin
        if (rst) begin
            iterationCounter <= '0;
        end else begin
            case (state)
                ST_ARR1, ST_ARR2, ST_SUMPP: iterationCounter <= LOOP_COUNT;  // RULE_03
                ST_LOOP1, ST_LOOP2, ST_LOOP3: iterationCounter <= iterationCounter - 6'd1; // RULE_02
                ST_DADJ: iterationCounter <= dividendGeDivisor ?
                                             LOOP_COUNT - 6'd1 : LOOP_COUNT; // RULE_17
                default: ;
            endcase
        end
    end

    // Divide flags and characteristic difference
    always_ff @(posedge clk) begin
        if (rst) begin
            zeroRemembered <= 1'b0;
            charDiff       <= '0;
        end else begin
            if (state == ST_DZERO) begin
                zeroRemembered <= fracZero;                            // RULE_14
            end
            if (state == ST_DOVF && !divOverflow && !zeroRemembered) begin
                charDiff <= acChar - {2'b00, srChar};                  // RULE_16
            end
        end
    end

    // Accumulator and multiplier-quotient register
    always_ff @(posedge clk) begin
        if (rst) begin
            acSign          <= 1'b0;
            acChar          <= '0;
            acFrac          <= '0;
            mqSign          <= 1'b0;
            mqChar          <= '0;
            mqFrac          <= '0;
            carryRemembered <= 1'b0;
        end else if (!busy && writeAccess) begin
            case (paddr)
                ACC_HEAD_OFS: begin
                    acSign <= pwdata[ACH_W];
                    acChar <= pwdata[ACH_W-1:0];
                end
                ACC_FRAC_OFS: acFrac <= pwdata[FRAC_W-1:0];
                MQ_HEAD_OFS: begin
                    mqSign <= pwdata[CHAR_W];
                    mqChar <= pwdata[CHAR_W-1:0];
                end
                MQ_FRAC_OFS: mqFrac <= pwdata[FRAC_W-1:0];
                default: ;
            endcase
        end else begin
            case (state)
                ST_MZERO: begin
                    if (fracZero) begin
                        acChar <= '0;
                        mqChar <= '0;
                    end else begin
                        acSign <= acSign ^ srSign;
                    end
                end
                ST_ARR1: acFrac <= '0;
                // Shift-and-add, carry of the add enters at the top
                ST_LOOP1, ST_LOOP2, ST_LOOP3: begin
                    if (mqFrac[0]) begin
                        {acFrac, mqFrac} <= {addSum, mqFrac[FRAC_W-1:1]};      // RULE_01
                    end else begin
                        {acFrac, mqFrac} <= {1'b0, acFrac, mqFrac[FRAC_W-1:1]}; // RULE_01
                    end
                end
                ST_ARR2: begin
                    acFrac <= '0;
                    mqFrac <= highMultiplier;
                end
                ST_CHAR: begin
                    acChar <= acChar + {2'b00, srChar} + BIAS_REMOVE;  // RULE_06
                    mqFrac <= '0;                                      // RULE_05
                end
                ST_SUMPP: begin
                    acFrac          <= addSum[FRAC_W-1:0] + latchFrac - srFrac; // RULE_07
                    mqFrac          <= highMultiplier;
                    carryRemembered <= ({1'b0, acFrac} + {1'b0, latchFrac}) > {1'b0, {FRAC_W{1'b1}}}; // RULE_07
                end
                ST_CARRY: begin
                    if (carryRemembered) begin
                        if (incSum[FRAC_W]) begin
                            {acFrac, mqFrac} <= {1'b1, incSum[FRAC_W-1:0], mqFrac[FRAC_W-1:1]}; // RULE_09
                        end else begin
                            acFrac <= incSum[FRAC_W-1:0];              // RULE_08
                        end
                    end
                end
                ST_NORM: begin
                    if (!acFrac[FRAC_W-1]) begin
                        {acFrac, mqFrac} <= {acFrac[FRAC_W-2:0], mqFrac, 1'b0}; // RULE_10
                        acChar <= acChar + CHAR_MINUS_ONE;             // RULE_10
                    end
                end
                ST_LOWCH: begin
                    if (fracZero) begin
                        acFrac <= '0;                                  // RULE_12
                        mqFrac <= '0;
                    end else begin
                        mqChar <= 8'(acChar + LOW_CHAR_ADD);           // RULE_11
                        mqSign <= acSign;
                    end
                end
                ST_DOVF: begin
                    if (!divOverflow && zeroRemembered) begin
                        acChar <= '0;                                  // RULE_15
                        mqChar <= '0;
                        acSign <= 1'b0;
                    end
                end
                ST_DADJ: begin
                    if (dividendGeDivisor) begin
                        acChar <= acChar + 10'd1;                      // RULE_17
                    end
                end
                default: ;
            endcase
        end
    end
    // Major loop enters from ST_SUMPP without clearing acFrac
endmodule
`default_nettype wire

/* rtl/dp_float_mul_div_seq_pkg.sv */
// Constants, register map and state codes of the double-precision sequencer
package dp_float_mul_div_seq_pkg;
    // ==========================================================
    // Register byte offsets
    localparam logic [7:0] CTRL_OFS     = 8'h00;
    localparam logic [7:0] STATUS_OFS   = 8'h04;
    localparam logic [7:0] ADDR_OFS     = 8'h08;
    localparam logic [7:0] ACC_HEAD_OFS = 8'h0C;
    localparam logic [7:0] ACC_FRAC_OFS = 8'h10;
    localparam logic [7:0] MQ_HEAD_OFS  = 8'h14;
    localparam logic [7:0] MQ_FRAC_OFS  = 8'h18;
    localparam logic [7:0] CHAR_DIFF_OFS = 8'h1C;
    // ==========================================================
    // Field positions
    localparam int CTRL_START_BIT  = 0;
    localparam int CTRL_DIVIDE_BIT = 1;
    localparam int STAT_BUSY_BIT   = 0;
    localparam int STAT_DCHK_BIT   = 1;
    localparam int STAT_ZERO_BIT   = 2;
    localparam int WORD_SIGN_BIT   = 35;
    // ==========================================================
    // Widths, counts and adder constants
    localparam int FRAC_W = 27;
    localparam int CHAR_W = 8;
    localparam int ACH_W  = 10;
    localparam int ADDR_W = 15;
    localparam logic [5:0]       LOOP_COUNT     = 6'o33;
    localparam logic [ACH_W-1:0] BIAS_REMOVE    = 10'h380;
    localparam logic [ACH_W-1:0] CHAR_MINUS_ONE = 10'h3FF;
    localparam logic [ACH_W-1:0] LOW_CHAR_ADD   = 10'h3E5;
    // ==========================================================
    // Sequencer states, one-hot
    typedef enum logic [17:0] {
        ST_IDLE   = 18'h00001,
        ST_FETCH1 = 18'h00002,
        ST_FETCH2 = 18'h00004,
        ST_MZERO  = 18'h00008,
        ST_ARR1   = 18'h00010,
        ST_LOOP1  = 18'h00020,
        ST_ARR2   = 18'h00040,
        ST_LOOP2  = 18'h00080,
        ST_CHAR   = 18'h00100,
        ST_SUMPP  = 18'h00200,
        ST_LOOP3  = 18'h00400,
        ST_CARRY  = 18'h00800,
        ST_NORM   = 18'h01000,
        ST_LOWCH  = 18'h02000,
        ST_DZERO  = 18'h04000,
        ST_DOVF   = 18'h08000,
        ST_DADJ   = 18'h10000,
        ST_DONE   = 18'h20000
    } seq_state_t;
endpackage

/* test/dp_float_mul_div_seq_props.sv */
// Port checker for the double-precision sequencer
`timescale 1ns/10ps
`default_nettype none
module dp_float_mul_div_seq_props
    import dp_float_mul_div_seq_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [7:0]        paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              memRead,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic              memAck,
    input wire logic [35:0]       memData,
    input wire logic              done,
    input wire logic              divideCheck
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // ==========================================================
    // Fetch steps
    sequence s_evenAck;
        memRead && memAck && !memAddr[0];
    endsequence
    sequence s_oddFetch;
        memRead && memAddr[0];
    endsequence
    sequence s_oddAck;
        memRead && memAck && memAddr[0];
    endsequence
    // ==========================================================
    // Bus and sequencer relations
    a_ready_always: assert property (pready) else $error("pready low");
    a_err_access: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    a_err_unmapped: assert property (psel && penable && paddr > CHAR_DIFF_OFS |-> pslverr)
        else $error("unmapped access accepted");
    a_done_pulse: assert property (done |=> !done) else $error("done longer than one cycle");
    a_fetch_even: assert property ($rose(memRead) |-> !memAddr[0]) else $error("odd first fetch");
    a_fetch_holds: assert property (memRead && !memAck |=> memRead && $stable(memAddr))
        else $error("fetch request dropped");
    a_odd_follows: assert property (s_evenAck |=> s_oddFetch ##0
        (memAddr[14:1] == $past(memAddr[14:1]))) else $error("second word address wrong");
    a_done_bounded: assert property (s_oddAck |-> ##[1:120] done) else $error("no done");
    a_check_ends: assert property ($rose(divideCheck) |-> ##[0:2] done)
        else $error("divide check without end");
    a_check_sticky: assert property (divideCheck && !(psel && penable && pwrite
        && paddr == STATUS_OFS && pwdata[STAT_DCHK_BIT]) |=> divideCheck)
        else $error("divide check lost");
endmodule
bind dp_float_mul_div_seq dp_float_mul_div_seq_props props (.clk(clk), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .memRead(memRead),
    .memAddr(memAddr), .memAck(memAck), .memData(memData), .done(done),
    .divideCheck(divideCheck));
`default_nettype wire

/* test/core_store_model.sv */
// Core storage model answering double-word operand fetches
`timescale 1ns/10ps
`default_nettype none
module core_store_model
    import dp_float_mul_div_seq_pkg::*;
(
    input wire logic              clk,
    input wire logic              rst,
    input wire logic              memRead,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire logic [1:0]        lag,
    output logic                  memAck,
    output logic [35:0]           memData
);
    logic [35:0] mem [0:15];
    logic [1:0]  cnt;
    // ==========================================================
    // Answer after lag cycles, scramble data outside the answer
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt <= 2'h0;
            memAck <= 1'b0;
            memData <= 36'h0;
        end else if (!memRead || memAck || cnt != lag) begin
            cnt <= (memRead && !memAck) ? cnt + 2'h1 : 2'h0;
            memAck <= 1'b0;
            memData <= ~memData;
        end else begin
            cnt <= 2'h0;
            memAck <= 1'b1;
            memData <= mem[memAddr[3:0]];
        end
    end
endmodule
`default_nettype wire

/* test/tb.sv */
// Self-checking bench for the double-precision sequencer
`timescale 1ns/10ps
`default_nettype none
module tb
    import dp_float_mul_div_seq_pkg::*;
;
    logic              clk, rst, psel, penable, pwrite, pready, pslverr;
    logic              memRead, memAck, done, divideCheck, rerr;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rdat;
    logic [ADDR_W-1:0] memAddr;
    logic [35:0]       memData;
    logic [1:0]        lag;
    int                mismatches = 0, checks = 0, cycles = 0;
    dp_float_mul_div_seq dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .memRead(memRead), .memAddr(memAddr), .memAck(memAck),
        .memData(memData), .done(done), .divideCheck(divideCheck));
    core_store_model core (.clk(clk), .rst(rst), .memRead(memRead), .memAddr(memAddr),
        .lag(lag), .memAck(memAck), .memData(memData));
    // ==========================================================
    // Clock and hang guard
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    // ==========================================================
    // Verdict, comparison and bus tasks
    task automatic conclude();
        if (mismatches == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rdat & m, e);
    endtask
    task automatic load(input logic [31:0] ah, af, mh, mf);
        xfer(1'b1, ADDR_OFS, 32'h5);
        xfer(1'b1, ACC_HEAD_OFS, ah);
        xfer(1'b1, ACC_FRAC_OFS, af);
        xfer(1'b1, MQ_HEAD_OFS, mh);
        xfer(1'b1, MQ_FRAC_OFS, mf);
    endtask
    task automatic waitDone();
        @(posedge clk);
        while (done !== 1'b1) @(posedge clk);
    endtask
    // ==========================================================
    // Multiply with expected result from the partial-product sum, divide with expected status bits
    task automatic mul(input logic sA, sC, input logic [7:0] cA, cC,
                       input logic [26:0] a, b, c, d);
        logic [54:0] t;
        logic [53:0] r;
        logic [9:0]  ch, lc;
        logic        sg;
        core.mem[4] = {sA, cA, a};
        core.mem[5] = {9'h1FF, b};
        load({21'h0, sC, 2'h0, cC}, {5'h0, c}, 32'h0, {5'h0, d});
        xfer(1'b1, CTRL_OFS, 32'h1);
        rd(STATUS_OFS, 32'h1, 32'h1);
        xfer(1'b1, ACC_FRAC_OFS, 32'h123);
        waitDone();
        t = 55'(a) * 55'(c) + ((55'(a) * 55'(d)) >> 27) + ((55'(b) * 55'(c)) >> 27);
        ch = 10'(cA) + 10'(cC) - 10'h080;
        sg = sA ^ sC;
        if (t[54]) r = t[54:1];
        else begin
            r = t[53:0];
            if (!r[53] && t != 0) begin
                r = r << 1;
                ch = ch - 10'h001;
            end
        end
        lc = ch - 10'd27;
        rd(ACC_FRAC_OFS, 32'hFFFFFFFF, {5'h0, r[53:27]});
        rd(MQ_FRAC_OFS, 32'hFFFFFFFF, {5'h0, r[26:0]});
        if (t == 0) begin
            rd(ACC_HEAD_OFS, 32'h3FF, 32'h0);
            rd(MQ_HEAD_OFS, 32'hFF, 32'h0);
        end else begin
            rd(ACC_HEAD_OFS, 32'h7FF, {21'h0, sg, ch});
            rd(MQ_HEAD_OFS, 32'h1FF, {23'h0, sg, lc[7:0]});
        end
    endtask
    task automatic dvd(input logic [31:0] ah, af, input logic [26:0] a, input logic [31:0] s);
        core.mem[4] = {1'b0, 8'h80, a};
        core.mem[5] = 36'h0;
        load(ah, af, 32'h1AB, 32'h0);
        xfer(1'b1, CTRL_OFS, 32'h3);
        waitDone();
        rd(STATUS_OFS, 32'h6, s);
    endtask
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        lag = 2'h0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(STATUS_OFS, 32'hFFFFFFFF, 32'h0);
        rd(ACC_FRAC_OFS, 32'hFFFFFFFF, 32'h0);
        rd(8'h40, 32'hFFFFFFFF, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        mul(1'b1, 1'b0, 8'h81, 8'h82, 27'h4000000, 27'h0, 27'h4000000, 27'h0);
        mul(1'b1, 1'b1, 8'h90, 8'h75, '1, '1, '1, '1);
        lag <= 2'h2;
        mul(1'b0, 1'b1, 8'h85, 8'h7A, 27'h4000001, 27'h7654321, 27'h6000000, 27'h0123456);
        mul(1'b0, 1'b0, 8'h85, 8'h7A, 27'h4000001, 27'h1, 27'h0, 27'h0);
        dvd({21'h0, 11'h081}, 32'h7000000, 27'h2000000, 32'h2);
        chk({31'h0, divideCheck}, 32'h1);
        xfer(1'b1, STATUS_OFS, 32'h2);
        rd(STATUS_OFS, 32'h2, 32'h0);
        dvd({21'h0, 11'h485}, 32'h0, 27'h4000000, 32'h4);
        rd(ACC_HEAD_OFS, 32'h7FF, 32'h0);
        rd(MQ_HEAD_OFS, 32'hFF, 32'h0);
        dvd({21'h0, 11'h090}, 32'h5000000, 27'h4000000, 32'h0);
        rd(CHAR_DIFF_OFS, 32'h3FF, 32'h10);
        rd(ACC_HEAD_OFS, 32'h3FF, 32'h091);
        rd(CTRL_OFS, 32'h2, 32'h2);
        conclude();
    end
endmodule
`default_nettype wire
